// [rsi_pkg.sv]
package rsi_pkg;
  localparam int REG_W = 8;
  localparam int ADDR_W_MIN = 10;
  localparam logic [7:0] IDX_RX_STATUS2 = 8'h14;
  localparam logic [7:0] IDX_SLIP_STATUS = 8'h15;
  localparam logic [7:0] IDX_IRQ_EN_PRI = 8'h16;
  localparam logic [7:0] IDX_IRQ_EN_SEC = 8'h17;
  localparam logic [7:0] IDX_PORT_ROUTE = 8'h30;
  localparam int BIT_SLIP = 0;
  localparam int BIT_LOCK_LOSS = 2;
  localparam int ROUTE_A_SRC = 0;
  localparam int ROUTE_A_SLAVE = 1;
  localparam int ROUTE_B_SRC = 2;
  localparam int ROUTE_B_SLAVE = 3;
  localparam int ROUTE_W = 4;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [3:0] RST_ROUTE = 4'h0;
  localparam int SYNC_STAGES = 2;

  typedef struct packed {
    logic cs_crc;
    logic parity;
    logic validity;
    logic biphase_error;
    logic subcode_change;
    logic lock_loss;
    logic subcode_crc;
    logic buffer_copy;
  } rsi_rx_status_t;

  typedef struct packed {
    logic sel;
    logic en;
    logic wr;
    logic [7:0] idx;
    logic aligned;
    logic [31:0] wdata;
  } rsi_apb_req_t;

  typedef enum logic [5:0] {
    SEL_NONE = 6'b000001,
    SEL_STATUS2 = 6'b000010,
    SEL_SLIP = 6'b000100,
    SEL_EN_PRI = 6'b001000,
    SEL_EN_SEC = 6'b010000,
    SEL_ROUTE = 6'b100000
  } rsi_sel_t;
endpackage : rsi_pkg

// [rsi_sync.sv]
`timescale 1ns/1ps
module rsi_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : rsi_sync

// [rsi_rx_irq.sv]
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
module rsi_rx_irq
  import rsi_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [REG_W-1:0] RX_EVENTS,
  input wire logic SLIP_A,
  input wire logic SLIP_B,
  output logic IRQ
);
  if (ADDR_W < ADDR_W_MIN) begin : g_chk
    $error("address bus too narrow for register map");
  end

  localparam int EV_W = REG_W + 2;

  // register index decode shared by read and write paths
  function automatic rsi_sel_t decode(input logic [7:0] idx,
                                      input logic aligned);
    if (!aligned) begin
      return SEL_NONE;
    end
    unique case (idx)
      IDX_RX_STATUS2: return SEL_STATUS2;
      IDX_SLIP_STATUS: return SEL_SLIP;
      IDX_IRQ_EN_PRI: return SEL_EN_PRI;
      IDX_IRQ_EN_SEC: return SEL_EN_SEC;
      IDX_PORT_ROUTE: return SEL_ROUTE;
      default: return SEL_NONE;
    endcase
  endfunction : decode

  logic [EV_W-1:0] ev_sync;
  rsi_rx_status_t rx_ev;
  logic slip_a;
  logic slip_b;
  logic slip_hit;
  rsi_apb_req_t req;
  rsi_sel_t sel;
  rsi_sel_t cap_sel;
  logic setup;
  logic access;
  logic [REG_W-1:0] rd_val;
  logic [REG_W-1:0] clr_status2;
  logic clr_slip;
  rsi_rx_status_t status2;
  logic slip;
  rsi_rx_status_t en_pri;
  logic en_sec;
  logic [ROUTE_W-1:0] route;
  rsi_rx_status_t next_status2;
  logic next_slip;

  // receiver and port slip events come from other clocks
  rsi_sync #(
    .W(EV_W)
  ) u_sync (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .d({SLIP_B, SLIP_A, RX_EVENTS}),
    .q(ev_sync)
  );

  assign rx_ev = rsi_rx_status_t'(ev_sync[REG_W-1:0]);
  assign slip_a = ev_sync[REG_W];
  assign slip_b = ev_sync[REG_W+1];

  // pick the port whose slip is reported
  always_comb begin
    if (route[ROUTE_A_SRC]) begin
      slip_hit = route[ROUTE_A_SLAVE] & slip_a;
    end else if (route[ROUTE_B_SRC]) begin
      slip_hit = route[ROUTE_B_SLAVE] & slip_b;
    end else begin
      slip_hit = 1'b0;
    end
  end

  // bus request carrier
  always_comb begin
    req.sel = PSEL;
    req.en = PENABLE;
    req.wr = PWRITE;
    req.idx = PADDR[9:2];
    req.aligned = (PADDR[1:0] == 2'b00) && (PADDR >> 10 == '0);
    req.wdata = PWDATA;
  end

  assign sel = decode(req.idx, req.aligned);
  assign setup = req.sel & ~req.en & ~PREADY;
  assign access = req.sel & req.en & PREADY;

  // read mux
  always_comb begin
    rd_val = '0;
    unique case (sel)
      SEL_STATUS2: rd_val = status2;
      SEL_SLIP: rd_val = {{(REG_W-1){1'b0}}, slip};
      SEL_EN_PRI: rd_val = en_pri;
      SEL_EN_SEC: rd_val = {{(REG_W-1){1'b0}}, en_sec};
      SEL_ROUTE: rd_val = {{(REG_W-ROUTE_W){1'b0}}, route};
      SEL_NONE: rd_val = '0;
    endcase
  end

  // apb answer: data captured in setup, ready in access
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
      cap_sel <= SEL_NONE;
    end else if (setup) begin
      PREADY <= 1'b1;
      PRDATA <= req.wr ? 32'h0000_0000 : {24'h00_0000, rd_val};
      PSLVERR <= (sel == SEL_NONE);
      cap_sel <= sel;
    end else begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end
  end

  // read clears only the bits that were returned
  always_comb begin
    clr_status2 = '0;
    clr_slip = 1'b0;
    if (access && !req.wr) begin
      if (cap_sel == SEL_STATUS2) begin
        clr_status2 = PRDATA[REG_W-1:0];
      end
      if (cap_sel == SEL_SLIP) begin
        clr_slip = PRDATA[BIT_SLIP];
      end
    end
  end

  // set wins over read clear; unlock re-sets while unlocked
  assign next_status2 = rsi_rx_status_t'((status2 & ~clr_status2) | rx_ev);
  assign next_slip = (slip & ~clr_slip) | slip_hit;

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      status2 <= rsi_rx_status_t'(RST_STATUS);
      slip <= 1'b0;
    end else begin
      status2 <= next_status2;
      slip <= next_slip;
    end
  end

  // mask registers, zero after reset keeps every source masked
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      en_pri <= rsi_rx_status_t'(RST_MASK);
      en_sec <= RST_MASK[BIT_SLIP];
    end else if (access && req.wr) begin
      if (cap_sel == SEL_EN_PRI) begin
        en_pri <= rsi_rx_status_t'(req.wdata[REG_W-1:0]);
      end
      if (cap_sel == SEL_EN_SEC) begin
        en_sec <= req.wdata[BIT_SLIP];
      end
    end
  end

  // port routing and mode seen by the slip selector
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      route <= RST_ROUTE;
    end else if (access && req.wr && cap_sel == SEL_ROUTE) begin
      route <= req.wdata[ROUTE_W-1:0];
    end
  end

  // interrupt request
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= (|(status2 & en_pri)) | (slip & en_sec);
    end
  end
endmodule : rsi_rx_irq

// [rsi_rx_irq_checker.sv]
`timescale 1ns/1ps
module rsi_rx_irq_checker
  import rsi_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic IRQ
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  wire logic [7:0] idx = PADDR[9:2];
  wire logic ok = PADDR[1:0] == 2'h0 && idx inside {8'h14, 8'h15, 8'h16,
    8'h17, 8'h30};
  a_ready_after_setup: assert property (PSEL && !PENABLE && !PREADY |=> PREADY)
    else $error("no ready");
  a_ready_one_cycle: assert property (PREADY |=> !PREADY)
    else $error("long ready");
  a_err_decode: assert property (PREADY |-> PSLVERR == !ok)
    else $error("bad error flag");
  a_err_with_ready: assert property (PSLVERR |-> PREADY)
    else $error("lone error");
  a_rdata_upper_zero: assert property (PREADY |-> PRDATA[31:8] == 24'h0)
    else $error("upper data set");
  a_slip_upper_zero: assert property (PREADY && !PWRITE &&
    idx == IDX_SLIP_STATUS |-> PRDATA[7:1] == 7'h0) else $error("slip upper");
  a_rdata_hold: assert property (!(PSEL && !PENABLE) |=> $stable(PRDATA))
    else $error("data moved");
  a_irq_quiet_reset: assert property ($fell(SYS_RST) |-> (!IRQ) [*3])
    else $error("irq after reset");
  c_err: cover property (PREADY && PSLVERR);
  c_irq_rise: cover property ($rose(IRQ));
  c_irq_fall: cover property ($fell(IRQ));
endmodule : rsi_rx_irq_checker

// [rx_slip_status_and_irq_mask_bench.sv]
`timescale 1ns/1ps
module rx_slip_status_and_irq_mask_bench;
  logic clk = 0, rst = 1, sel = 0, en = 0, wr = 0, sa = 0, sb = 0;
  logic [9:0] addr = 10'h0;
  logic [31:0] wd = 32'h0, rd;
  logic [7:0] ev = 8'h0;
  logic rdy, err, irq;
  logic [32:0] r;
  int n_errors = 0, total_checks = 0;
  always #5 clk = ~clk;
  rsi_rx_irq dut (.CORE_CLK(clk), .SYS_RST(rst), .PSEL(sel), .PENABLE(en),
    .PWRITE(wr), .PADDR(addr), .PWDATA(wd), .PRDATA(rd), .PREADY(rdy),
    .PSLVERR(err), .RX_EVENTS(ev), .SLIP_A(sa), .SLIP_B(sb), .IRQ(irq));
  task automatic end_of_test;
    if (n_errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    sel <= 1'b1;
    wr <= w;
    addr <= a;
    wd <= d;
    @(posedge clk);
    en <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1 && ++n < 20);
    if (rdy !== 1'b1) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, rdy, 1'b1);
    end
    r = {err, rd};
    sel <= 1'b0;
    en <= 1'b0;
  endtask : bus
  task automatic pulse(input logic [7:0] e, input logic a, input logic b);
    ev <= e;
    sa <= a;
    sb <= b;
    repeat (3) @(posedge clk);
    ev <= 8'h0;
    sa <= 1'b0;
    sb <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : pulse
  task automatic t_masks;
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, 10'h058, ~(32'h1 << i));
      pulse(8'h1 << i, 1'b0, 1'b0);
      chk({32'h0, irq}, 33'h0);
      bus(1'b1, 10'h058, 32'h1 << i);
      repeat (2) @(posedge clk);
      chk({32'h0, irq}, 33'h1);
      bus(1'b0, 10'h050, 32'h0);
      chk(r, 33'h1 << i);
      repeat (2) @(posedge clk);
      chk({32'h0, irq}, 33'h0);
    end
  endtask : t_masks
  task automatic t_slip;
    logic [7:0] tab [8] = '{8'h39, 8'h36, 8'h3b, 8'hf6, 8'hfb, 8'hc7,
      8'h46, 8'h1a};
    foreach (tab[k]) begin
      bus(1'b1, 10'h0c0, {28'h0, tab[k][7:4]});
      bus(1'b1, 10'h05c, {31'h0, tab[k][1]});
      pulse(8'h0, tab[k][3], tab[k][2]);
      chk({32'h0, irq}, {32'h0, tab[k][1] & tab[k][0]});
      bus(1'b0, 10'h054, 32'h0);
      chk(r, {32'h0, tab[k][0]});
    end
  endtask : t_slip
  task automatic t_refuse;
    bus(1'b0, 10'h100, 32'h0);
    chk(r, 33'h100000000);
    bus(1'b1, 10'h054, 32'hff);
    bus(1'b0, 10'h054, 32'h0);
    chk(r, 33'h0);
  endtask : t_refuse
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_masks;
    t_slip;
    t_refuse;
    end_of_test;
  end
  initial begin
    #100000;
    n_errors++;
    end_of_test;
  end
endmodule : rx_slip_status_and_irq_mask_bench
bind rsi_rx_irq rsi_rx_irq_checker #(.ADDR_W(ADDR_W)) u_chk (.*);
